// [rtl/e1ob_pkg.sv]
// Purpose: Shared constants and types for the E1 transmit overhead-bit insertion block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: All stored values reset to zero, so nothing is inserted after reset.
package e1ob_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_SRC = 8;
  localparam logic [IDX_W-1:0] IDX_INTL_ALIGN = 10'h0d2;
  localparam logic [IDX_W-1:0] IDX_INTL_NONALIGN = 10'h0d3;
  localparam logic [IDX_W-1:0] IDX_ALARM = 10'h0d4;
  localparam logic [IDX_W-1:0] IDX_NAT_BIT4 = 10'h0d5;
  localparam logic [IDX_W-1:0] IDX_NAT_BIT5 = 10'h0d6;
  localparam logic [IDX_W-1:0] IDX_NAT_BIT6 = 10'h0d7;
  localparam logic [IDX_W-1:0] IDX_NAT_BIT7 = 10'h0d8;
  localparam logic [IDX_W-1:0] IDX_NAT_BIT8 = 10'h0d9;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 10'h0da;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0db;
  localparam logic [DATA_W-1:0] RST_VALUE = 8'h00;

  // ****************************************************************
  // Insertion-control fields
  // ****************************************************************
  localparam int unsigned CTL_NAT_BIT8 = 0;
  localparam int unsigned CTL_NAT_BIT7 = 1;
  localparam int unsigned CTL_NAT_BIT6 = 2;
  localparam int unsigned CTL_NAT_BIT5 = 3;
  localparam int unsigned CTL_NAT_BIT4 = 4;
  localparam int unsigned CTL_ALARM = 5;
  localparam int unsigned CTL_INTL_NONALIGN = 6;
  localparam int unsigned CTL_INTL_ALIGN = 7;

  // Status fields: last frame number and whether that bit was replaced
  localparam int unsigned STS_FRAME_LSB = 0;
  localparam int unsigned STS_INSERTED = 4;

  // ****************************************************************
  // Overhead bit positions offered by the framer
  // ****************************************************************
  typedef enum logic [2:0] {
    POS_INTL, POS_ALARM, POS_NAT_BIT4, POS_NAT_BIT5, POS_NAT_BIT6, POS_NAT_BIT7, POS_NAT_BIT8
  } e1ob_pos_t;

  // Source index s is register IDX_INTL_ALIGN + s, enabled by control bit 7 - s
  localparam int unsigned SRC_INTL_ALIGN = 0;
  localparam int unsigned SRC_INTL_NONALIGN = 1;
  localparam int unsigned SRC_ALARM = 2;
  localparam int unsigned SRC_NAT_BIT4 = 3;
  localparam int unsigned SRC_NAT_BIT8 = 7;
  localparam int unsigned NUM_REGS = 9;
  localparam e1ob_pos_t SRC_POS_TAB [0:NUM_SRC-1] = '{
    POS_INTL, POS_INTL, POS_ALARM, POS_NAT_BIT4, POS_NAT_BIT5, POS_NAT_BIT6, POS_NAT_BIT7,
    POS_NAT_BIT8
  };
  // Only the align-frame source lives in even frames
  localparam logic [NUM_SRC-1:0] SRC_ODD_TAB = 8'hfe;

endpackage

// [rtl/e1ob_src_sel.sv]
// Purpose: One insertion source: decides whether it owns the offered bit and which value.
// Assumes: Frame number 0 to 15 within the multiframe; frame 0 is an align frame.
// Notes: Bit 7 of the stored value serves the first frame of its parity, bit 0 the last.
`timescale 1ns/1ps
module e1ob_src_sel #(
  parameter e1ob_pkg::e1ob_pos_t SRC_POS = e1ob_pkg::POS_INTL,
  parameter logic SRC_ODD = 1'b1
) (
  // Offered bit
  input wire logic ob_valid,
  input wire e1ob_pkg::e1ob_pos_t ob_pos,
  input wire logic [3:0] ob_frame,
  // Stored source
  input wire logic [7:0] src_values,
  input wire logic src_en,
  // Result
  output logic src_hit,
  output logic src_bit
);

  wire logic [2:0] slot;
  wire logic pos_match;

  // Frames of one parity descend from bit 7 to bit 0
  assign slot = ~ob_frame[3:1];
  assign pos_match = (ob_pos == SRC_POS) && (ob_frame[0] == SRC_ODD);
  assign src_hit = ob_valid && pos_match && src_en;
  assign src_bit = src_values[slot];

endmodule

// [rtl/e1ob_top.sv]
// Purpose: E1 transmit overhead-bit insertion with a classic Wishbone register slave.
// Assumes: The transmit framer runs on clk_sys and offers one overhead bit in each cycle that valid is high.
// Notes: One cycle from offered bit to output; the bus answers one cycle after a request.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module e1ob_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Framer side: offered overhead bit
  input wire logic ob_valid_i,
  input wire logic [3:0] ob_frame_i,
  input wire e1ob_pkg::e1ob_pos_t ob_pos_i,
  input wire logic ob_bit_i,
  // Framer side: resulting overhead bit
  output logic ob_valid_o,
  output logic ob_bit_o,
  output logic ob_inserted_o
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] regs_ff [0:e1ob_pkg::NUM_REGS-1];
  logic [7:0] status_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic valid_out_ff;
  logic bit_out_ff;
  logic inserted_ff;

  logic [7:0] nxt_status;
  logic nxt_valid_out;
  logic nxt_bit_out;
  logic nxt_inserted;
  logic [31:0] nxt_rdata;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire logic [e1ob_pkg::IDX_W-1:0] bus_idx;
  wire logic bus_req;
  wire logic bus_take;
  wire logic bus_wr;
  wire logic [e1ob_pkg::IDX_W-1:0] reg_off;
  wire logic in_store;
  wire logic is_status;
  wire logic [3:0] reg_sel;
  wire logic [7:0] rd_byte;

  // Byte lanes 1 to 3 carry nothing; only lane 0 reaches the registers
  assign bus_idx = wb_adr_i[11:2];
  assign bus_req = wb_cyc_i && wb_stb_i;
  // A request is taken once; ack falls in the cycle after it was given
  assign bus_take = bus_req && !ack_ff;
  assign bus_wr = bus_take && wb_we_i && wb_sel_i[0];
  assign reg_off = bus_idx - e1ob_pkg::IDX_INTL_ALIGN;
  assign in_store = (bus_idx >= e1ob_pkg::IDX_INTL_ALIGN) && (bus_idx <= e1ob_pkg::IDX_CONTROL);
  assign is_status = (bus_idx == e1ob_pkg::IDX_STATUS);
  assign reg_sel = reg_off[3:0];
  // Unmapped addresses read as zero and ignore writes
  assign rd_byte = in_store ? regs_ff[reg_sel] : (is_status ? status_ff : 8'h00);
  assign nxt_rdata = {24'h000000, rd_byte};

  // ****************************************************************
  // Register file
  // ****************************************************************
  genvar r;
  generate
    for (r = 0; r < e1ob_pkg::NUM_REGS; r = r + 1) begin : g_reg
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          regs_ff[r] <= e1ob_pkg::RST_VALUE;
        end else if (bus_wr && in_store && (reg_sel == 4'(r))) begin
          regs_ff[r] <= wb_dat_i[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_take;
      rdata_ff <= bus_take ? nxt_rdata : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ****************************************************************
  // Insertion sources
  // ****************************************************************
  wire logic [7:0] ctrl;
  wire logic [e1ob_pkg::NUM_SRC-1:0] src_hit;
  wire logic [e1ob_pkg::NUM_SRC-1:0] src_bit;
  wire logic any_hit;
  wire logic ins_bit;

  // Control is the last stored word. A write applies from the next offer on, not at
  // a multiframe boundary, so software should change it between multiframes.
  assign ctrl = regs_ff[e1ob_pkg::NUM_REGS-1];

  genvar s;
  generate
    for (s = 0; s < e1ob_pkg::NUM_SRC; s = s + 1) begin : g_src
      // Source s is enabled by control bit 7 - s
      e1ob_src_sel #(
        .SRC_POS(e1ob_pkg::SRC_POS_TAB[s]),
        .SRC_ODD(e1ob_pkg::SRC_ODD_TAB[s])
      ) u_sel (
        .ob_valid(ob_valid_i),
        .ob_pos(ob_pos_i),
        .ob_frame(ob_frame_i),
        .src_values(regs_ff[s]),
        .src_en(ctrl[e1ob_pkg::NUM_SRC-1-s]),
        .src_hit(src_hit[s]),
        .src_bit(src_bit[s])
      );
    end
  endgenerate

  // At most one source can own a position in a given frame
  assign any_hit = |src_hit;
  assign ins_bit = |(src_hit & src_bit);
  // Even-frame alarm and national positions are frame alignment bits and never hit
  assign nxt_bit_out = any_hit ? ins_bit : ob_bit_i;
  assign nxt_valid_out = ob_valid_i;
  assign nxt_inserted = ob_valid_i && any_hit;
  assign nxt_status = ob_valid_i ? {3'b000, any_hit, ob_frame_i} : status_ff;

  // ****************************************************************
  // Output stage
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      valid_out_ff <= 1'b0;
      bit_out_ff <= 1'b0;
      inserted_ff <= 1'b0;
      status_ff <= e1ob_pkg::RST_VALUE;
    end else begin
      valid_out_ff <= nxt_valid_out;
      bit_out_ff <= nxt_bit_out;
      inserted_ff <= nxt_inserted;
      status_ff <= nxt_status;
    end
  end

  // Registered outputs: the framer gets its bit back exactly one cycle after the offer
  assign ob_valid_o = valid_out_ff;
  assign ob_bit_o = bit_out_ff;
  assign ob_inserted_o = inserted_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // Independent expected bit per source, from the frame number
  wire logic [2:0] ast_slot;
  logic [7:0] ast_exp;
  assign ast_slot = 3'd7 - ob_frame_i[3:1];
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      ast_exp[k] = regs_ff[k][ast_slot];
    end
  end

  sequence s_offer(e1ob_pkg::e1ob_pos_t p, logic odd);
    ob_valid_i && (ob_pos_i == p) && (ob_frame_i[0] == odd);
  endsequence

  sequence s_replaced(logic expb);
    ob_valid_o && ob_inserted_o && (ob_bit_o == expb);
  endsequence

  property p_insert(e1ob_pkg::e1ob_pos_t p, logic odd, logic en, logic expb);
    s_offer(p, odd) ##0 en |=> s_replaced($past(expb));
  endproperty

  property p_keep(e1ob_pkg::e1ob_pos_t p, logic odd, logic en);
    s_offer(p, odd) ##0 !en |=> ob_valid_o && !ob_inserted_o && (ob_bit_o == $past(ob_bit_i));
  endproperty

  AST_NAT8_INSERT: assert property (p_insert(e1ob_pkg::POS_NAT_BIT8, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT8], ast_exp[7])) else $error("national bit 8 not inserted");
  AST_NAT7_INSERT: assert property (p_insert(e1ob_pkg::POS_NAT_BIT7, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT7], ast_exp[6])) else $error("national bit 7 not inserted");
  AST_NAT6_INSERT: assert property (p_insert(e1ob_pkg::POS_NAT_BIT6, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT6], ast_exp[5])) else $error("national bit 6 not inserted");
  AST_NAT5_INSERT: assert property (p_insert(e1ob_pkg::POS_NAT_BIT5, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT5], ast_exp[4])) else $error("national bit 5 not inserted");
  AST_NAT4_INSERT: assert property (p_insert(e1ob_pkg::POS_NAT_BIT4, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT4], ast_exp[3])) else $error("national bit 4 not inserted");
  AST_ALARM_INSERT: assert property (p_insert(e1ob_pkg::POS_ALARM, 1'b1,
    ctrl[e1ob_pkg::CTL_ALARM], ast_exp[2])) else $error("alarm bit not inserted");
  AST_NONALIGN_INSERT: assert property (p_insert(e1ob_pkg::POS_INTL, 1'b1,
    ctrl[e1ob_pkg::CTL_INTL_NONALIGN], ast_exp[1])) else $error("nonalign bit not inserted");
  AST_ALIGN_INSERT: assert property (p_insert(e1ob_pkg::POS_INTL, 1'b0,
    ctrl[e1ob_pkg::CTL_INTL_ALIGN], ast_exp[0])) else $error("align bit not inserted");

  // Fixed frame-to-bit corners
  AST_NAT_FRAME1: assert property (ob_valid_i && (ob_frame_i == 4'h1) &&
    (ob_pos_i == e1ob_pkg::POS_NAT_BIT4) && ctrl[e1ob_pkg::CTL_NAT_BIT4]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_NAT_BIT4][7]))
    else $error("national frame 1 not from bit 7");
  AST_NAT_FRAME15: assert property (ob_valid_i && (ob_frame_i == 4'hf) &&
    (ob_pos_i == e1ob_pkg::POS_NAT_BIT8) && ctrl[e1ob_pkg::CTL_NAT_BIT8]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_NAT_BIT8][0]))
    else $error("national frame 15 not from bit 0");
  AST_ALIGN_FRAME0: assert property (ob_valid_i && (ob_frame_i == 4'h0) &&
    (ob_pos_i == e1ob_pkg::POS_INTL) && ctrl[e1ob_pkg::CTL_INTL_ALIGN]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_INTL_ALIGN][7]))
    else $error("align frame 0 not from bit 7");
  AST_NONALIGN_FRAME15: assert property (ob_valid_i && (ob_frame_i == 4'hf) &&
    (ob_pos_i == e1ob_pkg::POS_INTL) && ctrl[e1ob_pkg::CTL_INTL_NONALIGN]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_INTL_NONALIGN][0]))
    else $error("nonalign frame 15 not from bit 0");
  AST_ALARM_FRAME1: assert property (ob_valid_i && (ob_frame_i == 4'h1) &&
    (ob_pos_i == e1ob_pkg::POS_ALARM) && ctrl[e1ob_pkg::CTL_ALARM]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_ALARM][7]))
    else $error("alarm frame 1 not from bit 7");
  // Further corners, so that both end bits of the national bit 4, align and alarm registers are pinned
  AST_NAT4_FRAME15: assert property (ob_valid_i && (ob_frame_i == 4'hf) &&
    (ob_pos_i == e1ob_pkg::POS_NAT_BIT4) && ctrl[e1ob_pkg::CTL_NAT_BIT4]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_NAT_BIT4][0]))
    else $error("national bit 4 frame 15 not from bit 0");
  AST_NAT5_FRAME3: assert property (ob_valid_i && (ob_frame_i == 4'h3) &&
    (ob_pos_i == e1ob_pkg::POS_NAT_BIT5) && ctrl[e1ob_pkg::CTL_NAT_BIT5]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_NAT_BIT4 + 1][6]))
    else $error("national bit 5 frame 3 not from bit 6");
  AST_NAT6_FRAME13: assert property (ob_valid_i && (ob_frame_i == 4'hd) &&
    (ob_pos_i == e1ob_pkg::POS_NAT_BIT6) && ctrl[e1ob_pkg::CTL_NAT_BIT6]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_NAT_BIT4 + 2][1]))
    else $error("national bit 6 frame 13 not from bit 1");
  AST_NAT7_FRAME7: assert property (ob_valid_i && (ob_frame_i == 4'h7) &&
    (ob_pos_i == e1ob_pkg::POS_NAT_BIT7) && ctrl[e1ob_pkg::CTL_NAT_BIT7]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_NAT_BIT4 + 3][4]))
    else $error("national bit 7 frame 7 not from bit 4");
  AST_ALIGN_FRAME14: assert property (ob_valid_i && (ob_frame_i == 4'he) &&
    (ob_pos_i == e1ob_pkg::POS_INTL) && ctrl[e1ob_pkg::CTL_INTL_ALIGN]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_INTL_ALIGN][0]))
    else $error("align frame 14 not from bit 0");
  AST_ALARM_FRAME15: assert property (ob_valid_i && (ob_frame_i == 4'hf) &&
    (ob_pos_i == e1ob_pkg::POS_ALARM) && ctrl[e1ob_pkg::CTL_ALARM]
    |=> ob_bit_o == $past(regs_ff[e1ob_pkg::SRC_ALARM][0]))
    else $error("alarm frame 15 not from bit 0");

  AST_PASS_DISABLED: assert property (p_keep(e1ob_pkg::POS_NAT_BIT4, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT4])) else $error("disabled source altered the bit");
  AST_PASS_NAT5: assert property (p_keep(e1ob_pkg::POS_NAT_BIT5, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT5])) else $error("disabled national bit 5 altered the bit");
  AST_PASS_NAT6: assert property (p_keep(e1ob_pkg::POS_NAT_BIT6, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT6])) else $error("disabled national bit 6 altered the bit");
  AST_PASS_NAT7: assert property (p_keep(e1ob_pkg::POS_NAT_BIT7, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT7])) else $error("disabled national bit 7 altered the bit");
  AST_PASS_NAT8: assert property (p_keep(e1ob_pkg::POS_NAT_BIT8, 1'b1,
    ctrl[e1ob_pkg::CTL_NAT_BIT8])) else $error("disabled national bit 8 altered the bit");
  AST_PASS_ALARM: assert property (p_keep(e1ob_pkg::POS_ALARM, 1'b1,
    ctrl[e1ob_pkg::CTL_ALARM])) else $error("disabled alarm source altered the bit");
  AST_PASS_NONALIGN: assert property (p_keep(e1ob_pkg::POS_INTL, 1'b1,
    ctrl[e1ob_pkg::CTL_INTL_NONALIGN])) else $error("disabled nonalign source altered the bit");
  AST_PASS_ALIGN: assert property (p_keep(e1ob_pkg::POS_INTL, 1'b0,
    ctrl[e1ob_pkg::CTL_INTL_ALIGN])) else $error("disabled align source altered the bit");
  AST_PASS_EVEN_ALARM: assert property (ob_valid_i && !ob_frame_i[0] &&
    (ob_pos_i != e1ob_pkg::POS_INTL) |=> !ob_inserted_o && (ob_bit_o == $past(ob_bit_i)))
    else $error("alignment bit position was altered");

  AST_BUS_ACK: assert property (bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");

  // ****************************************************************
  // Bus, output and status timing
  // ****************************************************************
  // Read data is zero outside ack, so a master that samples late sees nothing stale
  AST_DAT_IDLE_ZERO: assert property (!wb_ack_o |-> (wb_dat_o == 32'h00000000))
    else $error("read data not zero outside ack");
  AST_DAT_UPPER_ZERO: assert property (wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");
  AST_ACK_ONLY_REQ: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  AST_UNMAPPED_ZERO: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
    ((wb_adr_i[11:2] < e1ob_pkg::IDX_INTL_ALIGN) || (wb_adr_i[11:2] > e1ob_pkg::IDX_STATUS))
    |=> wb_ack_o && (wb_dat_o == 32'h00000000))
    else $error("unmapped read not answered with zero");

  AST_VALID_FOLLOWS: assert property (ob_valid_i |=> ob_valid_o)
    else $error("offered bit produced no output");
  AST_NO_SPARE_VALID: assert property (!ob_valid_i |=> !ob_valid_o)
    else $error("output valid without an offer");
  AST_INSERTED_QUAL: assert property (!ob_valid_o |-> !ob_inserted_o)
    else $error("inserted flag without valid output");
  AST_NO_INSERT_OFF: assert property ((ctrl == 8'h00) && ob_valid_i |=> !ob_inserted_o)
    else $error("bit replaced with every source disabled");
  AST_STATUS_TRACK: assert property (ob_valid_i |=>
    status_ff == {3'b000, ob_inserted_o, $past(ob_frame_i)})
    else $error("status does not track the last offered bit");
  AST_STATUS_HOLD: assert property (!ob_valid_i |=> $stable(status_ff))
    else $error("status changed without an offer");

  // Each stored register takes lane 0 at the taking edge and reads back unchanged
  genvar q;
  generate
    for (q = 0; q < e1ob_pkg::NUM_REGS; q = q + 1) begin : g_ast_reg
      AST_WRITE_LANDS: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
        wb_sel_i[0] && (wb_adr_i[11:2] == e1ob_pkg::IDX_INTL_ALIGN + 10'(q))
        |=> regs_ff[q] == $past(wb_dat_i[7:0]))
        else $error("register write did not land");
      AST_READ_RETURNS: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
        (wb_adr_i[11:2] == e1ob_pkg::IDX_INTL_ALIGN + 10'(q))
        |=> wb_ack_o && (wb_dat_o[7:0] == $past(regs_ff[q])))
        else $error("register read returned another value");
    end
  endgenerate

endmodule

// [bench/e1ob_framer_model.sv]
// Purpose: Behavioural transmit framer that offers overhead bits to the insertion block.
// Assumes: One offer per clk_sys cycle at most; lines change just after a rising edge.
// Notes: Between offers the frame and bit lines flip every cycle, so stale values are never trusted.
`timescale 1ns/1ps
module e1ob_framer_model (
  // Clock
  input wire logic clk_sys,
  // Offered overhead bit
  output logic ob_valid_i,
  output logic [3:0] ob_frame_i,
  output e1ob_pkg::e1ob_pos_t ob_pos_i,
  output logic ob_bit_i
);
  initial begin
    ob_valid_i = 1'b0;
    ob_frame_i = 4'h0;
    ob_pos_i = e1ob_pkg::POS_INTL;
    ob_bit_i = 1'b0;
  end

  // Gap 0 keeps valid high for a back-to-back offer; a gap idles that many cycles
  task automatic offer(input logic [3:0] f, input e1ob_pkg::e1ob_pos_t p, input logic b,
                       input int gap);
    @(posedge clk_sys);
    ob_valid_i <= 1'b1;
    ob_frame_i <= f;
    ob_pos_i <= p;
    ob_bit_i <= b;
    repeat (gap) begin
      @(posedge clk_sys);
      ob_valid_i <= 1'b0;
      ob_frame_i <= ~ob_frame_i;
      ob_bit_i <= ~ob_bit_i;
    end
  endtask
endmodule

// [bench/e1_tx_overhead_bit_insertion_bench.sv]
// Purpose: Self-checking bench for the E1 transmit overhead-bit insertion block.
// Assumes: Wishbone answers one cycle after it takes a request; one output per offered bit.
// Notes: Expected bits are queued at offer time and popped by the output monitor.
`timescale 1ns/1ps
module e1_tx_overhead_bit_insertion_bench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ob_valid_i, ob_bit_i, ob_valid_o, ob_bit_o, ob_inserted_o;
  logic [3:0] ob_frame_i;
  e1ob_pkg::e1ob_pos_t ob_pos_i;
  int fail_count = 0;
  int n_compared = 0;
  logic [7:0] regs [0:8];
  logic [1:0] exp_q [$];
  logic [31:0] rd;
  logic [7:0] ctrl;
  logic [1:0] e;

  always #2.5 clk_sys = ~clk_sys;

  e1ob_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ob_valid_i(ob_valid_i),
    .ob_frame_i(ob_frame_i), .ob_pos_i(ob_pos_i), .ob_bit_i(ob_bit_i),
    .ob_valid_o(ob_valid_o), .ob_bit_o(ob_bit_o), .ob_inserted_o(ob_inserted_o));
  e1ob_framer_model framer (.clk_sys(clk_sys), .ob_valid_i(ob_valid_i),
    .ob_frame_i(ob_frame_i), .ob_pos_i(ob_pos_i), .ob_bit_i(ob_bit_i));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Classic single cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk("wb ack latency", n, 32'd2);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Expected {inserted, bit}; source s sits at index align+s, enabled by control bit 7-s
  function automatic logic [1:0] predict(input logic [3:0] f, input e1ob_pkg::e1ob_pos_t p,
                                         input logic b);
    int s;
    s = -1;
    if (p == e1ob_pkg::POS_INTL) s = f[0] ? 1 : 0;
    else if (f[0]) s = 2 + int'(p) - int'(e1ob_pkg::POS_ALARM);
    if (s >= 0 && ctrl[7-s]) return {1'b1, regs[s][7-f[3:1]]};
    return {1'b0, b};
  endfunction

  always @(posedge clk_sys) begin
    if (ob_valid_o === 1'b1) begin
      if (exp_q.size() == 0) chk("spare output", 32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        chk("ob_bit_o", ob_bit_o, e[0]);
        chk("ob_inserted_o", ob_inserted_o, e[1]);
      end
    end
  end

  initial begin
    #100000;
    fail_count++;
    conclude();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic b;
    e1ob_pkg::e1ob_pos_t p;
    void'($urandom(99));
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i <= 9; i++) begin
      wb(1'b0, e1ob_pkg::IDX_INTL_ALIGN + i[9:0], 8'h00);
      chk("reset value", rd, 32'h0);
    end
    wb(1'b0, 10'h3ff, 8'h00);
    chk("unmapped read", rd, 32'h0);
    for (int r = 0; r < 12; r++) begin
      for (int i = 0; i < 9; i++) begin
        regs[i] = 8'($urandom);
        wb(1'b1, e1ob_pkg::IDX_INTL_ALIGN + i[9:0], regs[i]);
        wb(1'b0, e1ob_pkg::IDX_INTL_ALIGN + i[9:0], 8'h00);
        chk("reg readback", rd, {24'h0, regs[i]});
      end
      ctrl = (r < 8) ? 8'(1 << r) : (r == 8) ? 8'hff : (r == 9) ? 8'h00 : 8'($urandom);
      wb(1'b1, e1ob_pkg::IDX_CONTROL, ctrl);
      for (int f = 0; f < 16; f++) begin
        for (int k = 0; k < 7; k++) begin
          p = e1ob_pkg::e1ob_pos_t'(k[2:0]);
          b = 1'($urandom);
          exp_q.push_back(predict(f[3:0], p, b));
          framer.offer(f[3:0], p, b, (f == 15 && k == 6) ? 2 : int'($urandom_range(0, 1)));
        end
      end
      wb(1'b0, e1ob_pkg::IDX_STATUS, 8'h00);
      chk("status", rd, {27'h0, ctrl[0], 4'hf});
    end
    chk("queue left", exp_q.size(), 0);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    wb(1'b0, e1ob_pkg::IDX_CONTROL, 8'h00);
    chk("control after reset", rd, 32'h0);
    conclude();
  end
endmodule
